/* File: hw/dacr_top.sv */
// Configuration register bank of a two-channel converter with output word formatting.
// Assumes an APB master on CLOCK and conversion results from logic on the same clock.
//
// Overview of operation
// - Pattern zero: low 16 bits at 0x19, high 8 at 0x1a low byte.
// - Pattern one: low 8 bits at 0x1a high byte, upper 16 at 0x1b.
// - Channel B user byte from 0x1c high byte appended to its words.
// - Channel A user byte from 0x1c low byte appended to its words.
// - Gain calibration enables at 0x33 bits 13, 6 and 0x34 bit 4.
// - 0xc0 bit 7 picks channel B bandwidth: low-noise or wide.
// - 0xc0 bit 4 picks channel A bandwidth: low-noise or wide.
// - 0xc0 bits 1-0: none, B, A or both channels powered down.
// - 0xc1 bit 11 set turns internal reference off; external one needed.
// - 0xc1 bit 9: four lanes (A on 3,2; B on 1,0) or two.
// - 0xc1 bit 8 selects single data rate, clear means double.
// - 0xc2 bits 11-8 hold channel A input range code 0 to 5.
// - Pattern kind: 0/1 fixed zero, 2 ramp, 3 alternate zero and one.
// - Pattern on replaces channel B result with the test pattern.
`timescale 1ns/10ps
`include "dacr_params.svh"

module dacr_top (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Conversion results
	input wire logic CONV_VALID,
	input wire logic [17:0] CONV_A,
	input wire logic [17:0] CONV_B,
	output logic CONV_READY,
	// Output lanes
	output logic [15:0] OUTPUT_LANE_0,
	output logic [15:0] OUTPUT_LANE_1,
	output logic [15:0] OUTPUT_LANE_2,
	output logic [15:0] OUTPUT_LANE_3,
	output logic LANE_VALID,
	output logic LANE_FIRST,
	// Analog front end controls
	output logic CHAN_A_BANDWIDTH_SEL,
	output logic CHAN_B_BANDWIDTH_SEL,
	output logic PD_CHAN_A,
	output logic PD_CHAN_B,
	output logic INTERNAL_REFERENCE_OFF,
	output logic [3:0] CHAN_A_RANGE,
	// Data interface format
	output logic TWO_LANE_MODE,
	output logic SDR_MODE,
	// Calibration and initialization
	output logic GAIN_CAL_ENABLE_SECOND,
	output logic GAIN_CAL_ENABLE_THIRD,
	output logic GAIN_CAL_ENABLE_FOURTH,
	output logic INIT_ACCESS_OPEN,
	output logic INIT_READY_OK
);

	dacr_pkg::dacr_state_t s_r;
	dacr_pkg::dacr_state_t s_nxt;

	dacr_pat_if pat ();

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Map a byte address to a storage slot; hit is clear for unmapped words
	function automatic logic [4:0] slot_of(input logic [11:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		slot_of = 5'h00;
		if (addr[11:10] == 2'h0) begin
			unique case (idx)
				`DACR_IDX_PAT_CTRL: slot_of = {1'b1, `DACR_SLOT_PAT_CTRL};
				`DACR_IDX_PAT0_LOW: slot_of = {1'b1, `DACR_SLOT_PAT0_LOW};
				`DACR_IDX_PAT_MID: slot_of = {1'b1, `DACR_SLOT_PAT_MID};
				`DACR_IDX_PAT1_HIGH: slot_of = {1'b1, `DACR_SLOT_PAT1_HIGH};
				`DACR_IDX_USER_BITS: slot_of = {1'b1, `DACR_SLOT_USER_BITS};
				`DACR_IDX_GCAL_KEY: slot_of = {1'b1, `DACR_SLOT_GCAL_KEY};
				`DACR_IDX_GCAL_EXTRA: slot_of = {1'b1, `DACR_SLOT_GCAL_EXTRA};
				`DACR_IDX_READY_CODE: slot_of = {1'b1, `DACR_SLOT_READY_CODE};
				`DACR_IDX_BW_PD: slot_of = {1'b1, `DACR_SLOT_BW_PD};
				`DACR_IDX_REF_FMT: slot_of = {1'b1, `DACR_SLOT_REF_FMT};
				`DACR_IDX_RANGE_A: slot_of = {1'b1, `DACR_SLOT_RANGE_A};
				default: slot_of = 5'h00;
			endcase
		end
	endfunction

	// True when the address names the read-only status word
	function automatic logic is_status(input logic [11:0] addr);
		is_status = (addr[11:10] == 2'h0) && (addr[9:2] == `DACR_IDX_STATUS);
	endfunction

	// Merge the two low byte lanes of a write into a stored word
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		merge = old;
		if (strb[0]) begin
			merge[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			merge[15:8] = wd[15:8];
		end
	endfunction

	// Build an output word: 24 data bits then the user byte
	function automatic logic [31:0] out_word(input logic [23:0] data, input logic [7:0] user);
		out_word = {data, user};
	endfunction

	// ----------------------------------------
	// Field views of the stored registers
	// ----------------------------------------
	// Pattern words assembled across the three shared registers
	assign pat.pat0 = {s_r.regs[`DACR_SLOT_PAT_MID][7:0], s_r.regs[`DACR_SLOT_PAT0_LOW]};
	assign pat.pat1 = {s_r.regs[`DACR_SLOT_PAT1_HIGH], s_r.regs[`DACR_SLOT_PAT_MID][15:8]};
	assign pat.kind = s_r.regs[`DACR_SLOT_PAT_CTRL][`DACR_POS_PAT_KIND +: 2];
	assign pat.inc = s_r.regs[`DACR_SLOT_PAT_CTRL][`DACR_POS_RAMP_INC +: 4];
	// Generator only advances on accepted conversions while the pattern is on
	assign pat.step = CONV_VALID && s_r.conv_ready
		&& s_r.regs[`DACR_SLOT_PAT_CTRL][`DACR_POS_PAT_ON];

	dacr_patgen dacr_patgen_inst (
		.clk(CLOCK),
		.rst_n(RST_N),
		.pat(pat)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Bus, register file, output formatting and control outputs in one pass
	always_comb begin
		logic [4:0] hit;
		logic accept;
		logic [23:0] data_b;
		logic [31:0] word_a;
		logic [31:0] word_b;
		logic [15:0] status;
		logic [15:0] rr;
		hit = 5'h00;
		accept = 1'b0;
		data_b = 24'h000000;
		word_a = 32'h00000000;
		word_b = 32'h00000000;
		status = 16'h0000;
		rr = 16'h0000;
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.slverr = 1'b0;
		s_nxt.lane_valid = 1'b0;
		s_nxt.lane_first = 1'b0;

		// Status word shows live state of the block
		status = {12'h000, s_r.dropped, s_r.beat == dacr_pkg::BEAT_SECOND,
			s_r.ready_ok, s_r.init_open};

		// Setup phase: decode, load read data, answer in the next cycle
		if (PSEL && !PENABLE) begin
			hit = slot_of(PADDR);
			s_nxt.pready = 1'b1;
			s_nxt.slverr = (!hit[4] && !is_status(PADDR)) || (PADDR[1:0] != 2'h0);
			if (hit[4]) begin
				rr = s_r.regs[hit[3:0]];
			end else if (is_status(PADDR)) begin
				rr = status;
			end
			s_nxt.prdata = {16'h0000, rr};
		end

		// Access phase: the write lands at the completing edge
		if (PSEL && PENABLE && s_r.pready && !s_r.slverr) begin
			hit = slot_of(PADDR);
			if (PWRITE && hit[4]) begin
				// Reserved bits are stored as written; keeping them zero is the host's job
				s_nxt.regs[hit[3:0]] = merge(s_r.regs[hit[3:0]], PWDATA, PSTRB);
			end
			if (!PWRITE && is_status(PADDR)) begin
				s_nxt.dropped = 1'b0;
			end
		end

		// A conversion lost while busy is flagged; a new loss beats the read clear
		if (CONV_VALID && !s_r.conv_ready) begin
			s_nxt.dropped = 1'b1;
		end

		// ----------------------------------------
		// Output word formatting
		// ----------------------------------------
		accept = CONV_VALID && s_r.conv_ready;
		if (s_r.regs[`DACR_SLOT_PAT_CTRL][`DACR_POS_PAT_ON]) begin
			data_b = pat.word;
		end else begin
			data_b = {CONV_B, `DACR_CONV_PAD};
		end
		// Settings are sampled with the conversion, so changes act from the next word
		word_a = out_word({CONV_A, `DACR_CONV_PAD},
			s_r.regs[`DACR_SLOT_USER_BITS][`DACR_POS_USER_A +: 8]);
		word_b = out_word(data_b,
			s_r.regs[`DACR_SLOT_USER_BITS][`DACR_POS_USER_B +: 8]);
		// A powered-down channel sends zero words
		if (s_r.pd_a) begin
			word_a = 32'h00000000;
		end
		if (s_r.pd_b) begin
			word_b = 32'h00000000;
		end

		unique case (s_r.beat)
			dacr_pkg::BEAT_SECOND: begin
				// Low halves of the previous conversion on the two active lanes
				s_nxt.lane[3] = s_r.pend_a;
				s_nxt.lane[1] = s_r.pend_b;
				s_nxt.lane_valid = 1'b1;
				s_nxt.beat = dacr_pkg::BEAT_IDLE;
			end
			dacr_pkg::BEAT_IDLE: begin
				if (accept) begin
					s_nxt.lane_valid = 1'b1;
					s_nxt.lane_first = 1'b1;
					s_nxt.lane[3] = word_a[31:16];
					s_nxt.lane[1] = word_b[31:16];
					if (s_r.two_lane) begin
						// Two-lane mode needs a second beat; lanes 2 and 0 stay quiet
						s_nxt.lane[2] = 16'h0000;
						s_nxt.lane[0] = 16'h0000;
						s_nxt.pend_a = word_a[15:0];
						s_nxt.pend_b = word_b[15:0];
						s_nxt.beat = dacr_pkg::BEAT_SECOND;
					end else begin
						s_nxt.lane[2] = word_a[15:0];
						s_nxt.lane[0] = word_b[15:0];
					end
				end
			end
		endcase
		s_nxt.conv_ready = (s_nxt.beat == dacr_pkg::BEAT_IDLE);

		// ----------------------------------------
		// Control outputs from the updated registers
		// ----------------------------------------
		s_nxt.bw_b = s_nxt.regs[`DACR_SLOT_BW_PD][`DACR_POS_BW_B];
		s_nxt.bw_a = s_nxt.regs[`DACR_SLOT_BW_PD][`DACR_POS_BW_A];
		s_nxt.pd_b = s_nxt.regs[`DACR_SLOT_BW_PD][`DACR_POS_CHANNEL_POWERDOWN_SEL];
		s_nxt.pd_a = s_nxt.regs[`DACR_SLOT_BW_PD][`DACR_POS_CHANNEL_POWERDOWN_SEL + 1];
		s_nxt.ref_off = s_nxt.regs[`DACR_SLOT_REF_FMT][`DACR_POS_REF_OFF];
		s_nxt.two_lane = s_nxt.regs[`DACR_SLOT_REF_FMT][`DACR_POS_TWO_LANE];
		s_nxt.sdr = s_nxt.regs[`DACR_SLOT_REF_FMT][`DACR_POS_SDR];
		s_nxt.range_a = s_nxt.regs[`DACR_SLOT_RANGE_A][`DACR_POS_RANGE_A +: 4];
		s_nxt.gcal = {s_nxt.regs[`DACR_SLOT_GCAL_EXTRA][`DACR_POS_GCAL_FOURTH],
			s_nxt.regs[`DACR_SLOT_GCAL_KEY][`DACR_POS_GCAL_THIRD],
			s_nxt.regs[`DACR_SLOT_GCAL_KEY][`DACR_POS_GCAL_SECOND]};
		// Key and ready code are only reported; the host drives the sequence
		s_nxt.init_open = s_nxt.regs[`DACR_SLOT_GCAL_KEY][`DACR_POS_INIT_KEY +: 2]
			== `DACR_KEY_OPEN;
		s_nxt.ready_ok = s_nxt.regs[`DACR_SLOT_READY_CODE][`DACR_POS_READY_CODE +: 3]
			== `DACR_READY_GOOD;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Synchronous reset puts every register and output at zero except CONV_READY, which comes up high, and the beat state, which starts in BEAT_IDLE
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			s_r <= dacr_pkg::DACR_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs straight from the state
	// ----------------------------------------
	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.slverr;
	assign CONV_READY = s_r.conv_ready;
	assign OUTPUT_LANE_0 = s_r.lane[0];
	assign OUTPUT_LANE_1 = s_r.lane[1];
	assign OUTPUT_LANE_2 = s_r.lane[2];
	assign OUTPUT_LANE_3 = s_r.lane[3];
	assign LANE_VALID = s_r.lane_valid;
	assign LANE_FIRST = s_r.lane_first;
	assign CHAN_A_BANDWIDTH_SEL = s_r.bw_a;
	assign CHAN_B_BANDWIDTH_SEL = s_r.bw_b;
	assign PD_CHAN_A = s_r.pd_a;
	assign PD_CHAN_B = s_r.pd_b;
	assign INTERNAL_REFERENCE_OFF = s_r.ref_off;
	assign CHAN_A_RANGE = s_r.range_a;
	assign TWO_LANE_MODE = s_r.two_lane;
	assign SDR_MODE = s_r.sdr;
	assign GAIN_CAL_ENABLE_SECOND = s_r.gcal[0];
	assign GAIN_CAL_ENABLE_THIRD = s_r.gcal[1];
	assign GAIN_CAL_ENABLE_FOURTH = s_r.gcal[2];
	assign INIT_ACCESS_OPEN = s_r.init_open;
	assign INIT_READY_OK = s_r.ready_ok;

endmodule

/* File: hw/dacr_params.svh */
// Offsets, field positions, values and reset value of the converter configuration block.
// Assumes inclusion by bare name; definitions only.
`ifndef DACR_PARAMS_SVH
`define DACR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define DACR_IDX_PAT_CTRL 8'h18
`define DACR_IDX_PAT0_LOW 8'h19
`define DACR_IDX_PAT_MID 8'h1A
`define DACR_IDX_PAT1_HIGH 8'h1B
`define DACR_IDX_USER_BITS 8'h1C
`define DACR_IDX_GCAL_KEY 8'h33
`define DACR_IDX_GCAL_EXTRA 8'h34
`define DACR_IDX_READY_CODE 8'h37
`define DACR_IDX_STATUS 8'h3F
`define DACR_IDX_BW_PD 8'hC0
`define DACR_IDX_REF_FMT 8'hC1
`define DACR_IDX_RANGE_A 8'hC2

// ----------------------------------------
// Storage slots of the writable registers
// ----------------------------------------
`define DACR_SLOTS 11
`define DACR_SLOT_PAT_CTRL 4'h0
`define DACR_SLOT_PAT0_LOW 4'h1
`define DACR_SLOT_PAT_MID 4'h2
`define DACR_SLOT_PAT1_HIGH 4'h3
`define DACR_SLOT_USER_BITS 4'h4
`define DACR_SLOT_GCAL_KEY 4'h5
`define DACR_SLOT_GCAL_EXTRA 4'h6
`define DACR_SLOT_READY_CODE 4'h7
`define DACR_SLOT_BW_PD 4'h8
`define DACR_SLOT_REF_FMT 4'h9
`define DACR_SLOT_RANGE_A 4'hA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DACR_POS_PAT_ON 1
`define DACR_POS_PAT_KIND 2
`define DACR_POS_RAMP_INC 4
`define DACR_POS_USER_B 8
`define DACR_POS_USER_A 0
`define DACR_POS_GCAL_THIRD 13
`define DACR_POS_GCAL_SECOND 6
`define DACR_POS_INIT_KEY 4
`define DACR_POS_GCAL_FOURTH 4
`define DACR_POS_READY_CODE 0
`define DACR_POS_BW_B 7
`define DACR_POS_BW_A 4
`define DACR_POS_CHANNEL_POWERDOWN_SEL 0
`define DACR_POS_REF_OFF 11
`define DACR_POS_TWO_LANE 9
`define DACR_POS_SDR 8
`define DACR_POS_RANGE_A 8

// ----------------------------------------
// Values and reset
// ----------------------------------------
`define DACR_KEY_OPEN 2'h3
`define DACR_READY_GOOD 3'h5
`define DACR_PAT_KIND_RAMP 2'h2
`define DACR_PAT_KIND_ALT 2'h3
`define DACR_REG_RST 16'h0000
`define DACR_CONV_PAD 6'h00

`endif

/* File: hw/dacr_pkg.sv */
// Types shared by the converter configuration block.
// Assumes dacr_params.svh is on the include path.
`include "dacr_params.svh"

package dacr_pkg;

	// Output beat sequencer states
	typedef enum logic [1:0] {
		BEAT_IDLE = 2'b01,
		BEAT_SECOND = 2'b10
	} dacr_beat_t;

	// Whole state of the top module
	typedef struct packed {
		logic [`DACR_SLOTS-1:0][15:0] regs;
		logic pready;
		logic slverr;
		logic [31:0] prdata;
		logic dropped;
		dacr_beat_t beat;
		logic [15:0] pend_a;
		logic [15:0] pend_b;
		logic [3:0][15:0] lane;
		logic lane_valid;
		logic lane_first;
		logic conv_ready;
		logic bw_a;
		logic bw_b;
		logic pd_a;
		logic pd_b;
		logic ref_off;
		logic two_lane;
		logic sdr;
		logic [3:0] range_a;
		logic [2:0] gcal;
		logic init_open;
		logic ready_ok;
	} dacr_state_t;

	localparam dacr_state_t DACR_STATE_RST = '{
		regs: '0, pready: 1'b0, slverr: 1'b0, prdata: 32'h00000000, dropped: 1'b0,
		beat: BEAT_IDLE, pend_a: 16'h0000, pend_b: 16'h0000, lane: '0,
		lane_valid: 1'b0, lane_first: 1'b0, conv_ready: 1'b1, bw_a: 1'b0, bw_b: 1'b0,
		pd_a: 1'b0, pd_b: 1'b0, ref_off: 1'b0, two_lane: 1'b0, sdr: 1'b0,
		range_a: 4'h0, gcal: 3'h0, init_open: 1'b0, ready_ok: 1'b0
	};

	// State of the pattern generator
	typedef struct packed {
		logic [23:0] ramp;
		logic alt_sel;
	} dacr_gen_state_t;

	localparam dacr_gen_state_t DACR_GEN_RST = '{ramp: 24'h000000, alt_sel: 1'b0};

endpackage

/* File: hw/dacr_pat_if.sv */
// Bundle between the register block and the channel B pattern generator.
// Assumes both ends share one clock.
`timescale 1ns/10ps

interface dacr_pat_if;
	logic step;
	logic [1:0] kind;
	logic [3:0] inc;
	logic [23:0] pat0;
	logic [23:0] pat1;
	logic [23:0] word;

	modport gen (input step, input kind, input inc, input pat0, input pat1, output word);
	modport user (output step, output kind, output inc, output pat0, output pat1, input word);
endinterface

/* File: hw/dacr_patgen.sv */
// Channel B test pattern generator: fixed, ramp and alternating words.
// Assumes step pulses once per accepted conversion while the pattern is on.
`timescale 1ns/10ps
`include "dacr_params.svh"

module dacr_patgen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pattern bundle
	dacr_pat_if.gen pat
);

	dacr_pkg::dacr_gen_state_t s_r;
	dacr_pkg::dacr_gen_state_t s_nxt;

	// ----------------------------------------
	// Word selection
	// ----------------------------------------
	// Word is the one for the current conversion; the step moves to the next
	always_comb begin
		unique case (pat.kind)
			`DACR_PAT_KIND_RAMP: pat.word = s_r.ramp;
			`DACR_PAT_KIND_ALT: pat.word = s_r.alt_sel ? pat.pat1 : pat.pat0;
			default: pat.word = pat.pat0;
		endcase
	end

	// Next state: ramp steps by increment plus one, alternation toggles
	always_comb begin
		s_nxt = s_r;
		if (pat.step) begin
			s_nxt.ramp = s_r.ramp + {20'h00000, pat.inc} + 24'h000001;
			s_nxt.alt_sel = ~s_r.alt_sel;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= dacr_pkg::DACR_GEN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

/* File: tb/dacr_top_checker.sv */
// Protocol and register-effect assertions for the converter configuration block.
// Assumes binding to dacr_top and that no write lands within two cycles of a conversion.
`timescale 1ns/10ps

module dacr_checker (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Conversions and lanes
	input wire logic CONV_VALID,
	input wire logic [17:0] CONV_A,
	input wire logic CONV_READY,
	input wire logic [15:0] OUTPUT_LANE_3,
	input wire logic [15:0] OUTPUT_LANE_2,
	input wire logic LANE_VALID,
	input wire logic LANE_FIRST,
	// Controls
	input wire logic CHAN_B_BANDWIDTH_SEL,
	input wire logic PD_CHAN_A,
	input wire logic PD_CHAN_B,
	input wire logic INTERNAL_REFERENCE_OFF,
	input wire logic TWO_LANE_MODE,
	input wire logic [3:0] CHAN_A_RANGE,
	input wire logic INIT_ACCESS_OPEN
);
	// ------------------------------
	// Sequences and properties
	// ------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	// Completed error-free write of both low bytes; controls show it one edge on
	sequence s_wr(a);
		PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == a && PSTRB[1:0] == 2'h3;
	endsequence
	sequence s_acc;
		CONV_VALID && CONV_READY;
	endsequence
	sequence s_two_beats;
		LANE_VALID && LANE_FIRST && !CONV_READY ##1 LANE_VALID && !LANE_FIRST && CONV_READY;
	endsequence

	ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	misalign_error_a: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
		else $error("misaligned access not refused");
	bandwidth_b_a: assert property (s_wr(12'h300) |-> ##2
		CHAN_B_BANDWIDTH_SEL == $past(PWDATA[7], 2))
		else $error("bandwidth select wrong");
	powerdown_map_a: assert property (s_wr(12'h300) |-> ##2
		{PD_CHAN_A, PD_CHAN_B} == $past(PWDATA[1:0], 2))
		else $error("power-down decode wrong");
	ref_lanes_a: assert property (s_wr(12'h304) |-> ##2
		{INTERNAL_REFERENCE_OFF, TWO_LANE_MODE} == {$past(PWDATA[11], 2), $past(PWDATA[9], 2)})
		else $error("reference or lane select wrong");
	range_a_a: assert property (s_wr(12'h308) |-> ##2
		CHAN_A_RANGE == $past(PWDATA[11:8], 2))
		else $error("range code wrong");
	init_key_a: assert property (s_wr(12'h0CC) |-> ##2
		INIT_ACCESS_OPEN == ($past(PWDATA[5:4], 2) == 2'h3))
		else $error("init key decode wrong");
	lane_answer_a: assert property (s_acc |=> LANE_VALID && LANE_FIRST)
		else $error("no beat after conversion");
	two_lane_beats_a: assert property (s_acc ##0 TWO_LANE_MODE |=> s_two_beats)
		else $error("two-lane beats wrong");
	lane_a_data_a: assert property (s_acc ##0 !TWO_LANE_MODE && !PD_CHAN_A |=>
		OUTPUT_LANE_3 == $past(CONV_A[17:2]))
		else $error("channel A high lane wrong");
	pd_zero_a: assert property (s_acc ##0 !TWO_LANE_MODE && PD_CHAN_A |=>
		OUTPUT_LANE_3 == 16'h0000 && OUTPUT_LANE_2 == 16'h0000)
		else $error("powered-down word not zero");
endmodule

bind dacr_top dacr_checker dacr_checker_inst (
	.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.CONV_VALID(CONV_VALID), .CONV_A(CONV_A), .CONV_READY(CONV_READY),
	.OUTPUT_LANE_3(OUTPUT_LANE_3), .OUTPUT_LANE_2(OUTPUT_LANE_2), .LANE_VALID(LANE_VALID),
	.LANE_FIRST(LANE_FIRST), .CHAN_B_BANDWIDTH_SEL(CHAN_B_BANDWIDTH_SEL), .PD_CHAN_A(PD_CHAN_A),
	.PD_CHAN_B(PD_CHAN_B), .INTERNAL_REFERENCE_OFF(INTERNAL_REFERENCE_OFF),
	.TWO_LANE_MODE(TWO_LANE_MODE), .CHAN_A_RANGE(CHAN_A_RANGE), .INIT_ACCESS_OPEN(INIT_ACCESS_OPEN)
);

/* File: tb/dacr_top_bench.sv */
// Self-checking bench for the converter configuration block over APB.
// Assumes dacr_params.svh on the include path and the checker bound to dacr_top.
`timescale 1ns/10ps
`include "dacr_params.svh"

module dacr_top_bench;
	// ------------------------------
	// Signals
	// ------------------------------
	logic CLOCK = 1'h0;
	logic RST_N = 1'h0;
	logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, CONV_VALID = 1'h0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h00000000;
	logic [3:0] PSTRB = 4'hF;
	logic [17:0] CONV_A = 18'h00000, CONV_B = 18'h00000;
	logic [31:0] PRDATA, rd, wa, wb;
	logic PREADY, PSLVERR, CONV_READY, LANE_VALID, LANE_FIRST, err, rdy1;
	logic [15:0] OUTPUT_LANE_0, OUTPUT_LANE_1, OUTPUT_LANE_2, OUTPUT_LANE_3;
	logic CHAN_A_BANDWIDTH_SEL, CHAN_B_BANDWIDTH_SEL, PD_CHAN_A, PD_CHAN_B, INIT_READY_OK;
	logic INTERNAL_REFERENCE_OFF, TWO_LANE_MODE, SDR_MODE, INIT_ACCESS_OPEN;
	logic GAIN_CAL_ENABLE_SECOND, GAIN_CAL_ENABLE_THIRD, GAIN_CAL_ENABLE_FOURTH;
	logic [3:0] CHAN_A_RANGE, flags;
	logic [63:0] b1, b2;
	logic [23:0] ramp0;
	logic [7:0] idx [10] = '{`DACR_IDX_PAT0_LOW, `DACR_IDX_PAT_MID, `DACR_IDX_PAT1_HIGH,
		`DACR_IDX_USER_BITS, `DACR_IDX_GCAL_KEY, `DACR_IDX_GCAL_EXTRA, `DACR_IDX_READY_CODE,
		`DACR_IDX_BW_PD, `DACR_IDX_REF_FMT, `DACR_IDX_RANGE_A};
	// Documented fields of each register; the host leaves reserved bits at zero
	logic [15:0] msk [10] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h2070, 16'h0010,
		16'h0007, 16'h0093, 16'h0B00, 16'h0F00};
	int errors = 0;
	int total_checks = 0;

	dacr_top dacr_top_inst (
		.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CONV_VALID(CONV_VALID), .CONV_A(CONV_A), .CONV_B(CONV_B),
		.CONV_READY(CONV_READY), .OUTPUT_LANE_0(OUTPUT_LANE_0), .OUTPUT_LANE_1(OUTPUT_LANE_1),
		.OUTPUT_LANE_2(OUTPUT_LANE_2), .OUTPUT_LANE_3(OUTPUT_LANE_3), .LANE_VALID(LANE_VALID),
		.LANE_FIRST(LANE_FIRST), .CHAN_A_BANDWIDTH_SEL(CHAN_A_BANDWIDTH_SEL),
		.CHAN_B_BANDWIDTH_SEL(CHAN_B_BANDWIDTH_SEL), .PD_CHAN_A(PD_CHAN_A), .PD_CHAN_B(PD_CHAN_B),
		.INTERNAL_REFERENCE_OFF(INTERNAL_REFERENCE_OFF), .CHAN_A_RANGE(CHAN_A_RANGE),
		.TWO_LANE_MODE(TWO_LANE_MODE), .SDR_MODE(SDR_MODE),
		.GAIN_CAL_ENABLE_SECOND(GAIN_CAL_ENABLE_SECOND), .GAIN_CAL_ENABLE_THIRD(GAIN_CAL_ENABLE_THIRD),
		.GAIN_CAL_ENABLE_FOURTH(GAIN_CAL_ENABLE_FOURTH), .INIT_ACCESS_OPEN(INIT_ACCESS_OPEN),
		.INIT_READY_OK(INIT_READY_OK)
	);

	// ------------------------------
	// Clock, helpers and bus tasks
	// ------------------------------
	always #4 CLOCK = ~CLOCK;

	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; holds the request until ready, then idles one cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= {16'h0000, d};
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		@(posedge CLOCK);
		while (PREADY !== 1'h1) @(posedge CLOCK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CLOCK);
	endtask

	// Write, then let the control outputs catch up
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		apb(1'h1, ad(i), d);
		@(posedge CLOCK);
	endtask

	// One conversion pulse; both beats captured as the lanes stand
	task automatic conv(input logic [17:0] a, input logic [17:0] b);
		CONV_VALID <= 1'h1;
		CONV_A <= a;
		CONV_B <= b;
		@(posedge CLOCK);
		CONV_VALID <= 1'h0;
		@(posedge CLOCK);
		b1 = {OUTPUT_LANE_3, OUTPUT_LANE_2, OUTPUT_LANE_1, OUTPUT_LANE_0};
		flags[3:2] = {LANE_VALID, LANE_FIRST};
		rdy1 = CONV_READY;
		@(posedge CLOCK);
		b2 = {OUTPUT_LANE_3, OUTPUT_LANE_2, OUTPUT_LANE_1, OUTPUT_LANE_0};
		flags[1:0] = {LANE_VALID, LANE_FIRST};
		@(posedge CLOCK);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge CLOCK);
		errors++;
		$display("watchdog expired");
		stop_test();
	end

	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		wa = {18'h2ABCD, 6'h00, 8'hA5};
		wb = {18'h15A3C, 6'h00, 8'hB7};
		repeat (8) @(posedge CLOCK);
		RST_N <= 1'h1;
		@(posedge CLOCK);
		chk("reset outputs", {CONV_READY, TWO_LANE_MODE, SDR_MODE, INIT_ACCESS_OPEN,
			CHAN_A_RANGE}, 32'h80);
		foreach (idx[i]) begin
			apb(1'h0, ad(idx[i]), 16'h0000);
			chk("reset value", rd, 32'h0);
			apb(1'h1, ad(idx[i]), {idx[i], ~idx[i]} & msk[i]);
			apb(1'h0, ad(idx[i]), 16'h0000);
			chk("read back", rd, {16'h0000, ({idx[i], ~idx[i]} & msk[i])});
		end
		apb(1'h0, ad(8'h20), 16'h0000);
		chk("unmapped error", err, 1'h1);
		apb(1'h0, ad(`DACR_IDX_BW_PD) + 12'h002, 16'h0000);
		chk("misaligned error", err, 1'h1);
		$display("test register table done");

		for (logic [3:0] k = 0; k < 4; k++) begin
			wr(`DACR_IDX_BW_PD, {8'h00, k[0], 2'h0, k[1], 2'h0, k[1:0]});
			chk("bandwidth power-down", {CHAN_B_BANDWIDTH_SEL, CHAN_A_BANDWIDTH_SEL, PD_CHAN_A, PD_CHAN_B},
				{k[0], k[1], k[1], k[0]});
		end
		for (logic [3:0] k = 0; k < 8; k++) begin
			wr(`DACR_IDX_REF_FMT, {4'h0, k[2], 1'h0, k[1:0], 8'h00});
			chk("reference lanes rate",
				{INTERNAL_REFERENCE_OFF, TWO_LANE_MODE, SDR_MODE}, k);
		end
		for (logic [3:0] k = 0; k < 6; k++) begin
			wr(`DACR_IDX_RANGE_A, {4'h0, k, 8'h00});
			chk("range code", CHAN_A_RANGE, k);
		end
		wr(`DACR_IDX_GCAL_KEY, 16'h2070);
		wr(`DACR_IDX_GCAL_EXTRA, 16'h0010);
		wr(`DACR_IDX_READY_CODE, 16'h0005);
		chk("cal key ready set", {GAIN_CAL_ENABLE_SECOND, GAIN_CAL_ENABLE_THIRD, GAIN_CAL_ENABLE_FOURTH,
			INIT_ACCESS_OPEN, INIT_READY_OK}, 5'h1F);
		wr(`DACR_IDX_GCAL_KEY, 16'h0000);
		wr(`DACR_IDX_GCAL_EXTRA, 16'h0000);
		wr(`DACR_IDX_READY_CODE, 16'h0004);
		chk("cal key ready clear", {GAIN_CAL_ENABLE_SECOND, GAIN_CAL_ENABLE_THIRD, GAIN_CAL_ENABLE_FOURTH,
			INIT_ACCESS_OPEN, INIT_READY_OK}, 5'h00);
		$display("test controls done");

		wr(`DACR_IDX_BW_PD, 16'h0000);
		wr(`DACR_IDX_REF_FMT, 16'h0000);
		wr(`DACR_IDX_USER_BITS, 16'hB7A5);
		wr(`DACR_IDX_PAT_CTRL, 16'h0000);
		conv(18'h2ABCD, 18'h15A3C);
		chk("four-lane words", b1, {wa, wb});
		chk("four-lane flags", flags[3:2], 2'h3);
		wr(`DACR_IDX_BW_PD, 16'h0003);
		conv(18'h2ABCD, 18'h15A3C);
		chk("powered-down words", b1, 64'h0);
		wr(`DACR_IDX_BW_PD, 16'h0000);
		wr(`DACR_IDX_REF_FMT, 16'h0200);
		conv(18'h2ABCD, 18'h15A3C);
		chk("two-lane first beat", b1, {wa[31:16], 16'h0000, wb[31:16], 16'h0000});
		chk("two-lane second beat", {b2[63:48], b2[31:16]}, {wa[15:0], wb[15:0]});
		chk("two-lane flags", {flags, rdy1}, 5'h1C);
		CONV_VALID <= 1'h1;
		@(posedge CLOCK);
		@(posedge CLOCK);
		CONV_VALID <= 1'h0;
		repeat (3) @(posedge CLOCK);
		apb(1'h0, ad(`DACR_IDX_STATUS), 16'h0000);
		chk("drop flagged", rd, 32'h8);
		apb(1'h0, ad(`DACR_IDX_STATUS), 16'h0000);
		chk("drop cleared", rd, 32'h0);
		$display("test lanes done");

		wr(`DACR_IDX_REF_FMT, 16'h0000);
		wr(`DACR_IDX_PAT0_LOW, 16'h3456);
		wr(`DACR_IDX_PAT_MID, 16'h9A12);
		wr(`DACR_IDX_PAT1_HIGH, 16'h78BC);
		wr(`DACR_IDX_PAT_CTRL, 16'h000E);
		conv(18'h2ABCD, 18'h15A3C);
		chk("alternate first", b1[31:0], {24'h123456, 8'hB7});
		conv(18'h2ABCD, 18'h15A3C);
		chk("alternate second", b1[31:0], {24'h78BC9A, 8'hB7});
		wr(`DACR_IDX_PAT_CTRL, 16'h0006);
		conv(18'h2ABCD, 18'h15A3C);
		chk("fixed pattern", b1[31:0], {24'h123456, 8'hB7});
		chk("channel A kept", b1[63:32], wa);
		wr(`DACR_IDX_PAT_CTRL, 16'h005A);
		conv(18'h2ABCD, 18'h15A3C);
		ramp0 = b1[31:8];
		conv(18'h2ABCD, 18'h15A3C);
		chk("ramp step", b1[31:8] - ramp0, 24'h000006);
		wr(`DACR_IDX_PAT_CTRL, 16'h0000);
		conv(18'h2ABCD, 18'h15A3C);
		chk("pattern off", b1[31:0], wb);
		$display("test patterns done");
		stop_test();
	end
endmodule
